// ===== borc_brownout_ctrl.sv
// brown-out reset control register with APB access and effective-enable output
// assumes undervoltage_reset and warm_reset are synchronous levels; config strap stable at reset
// Functional notes
// - with config mode 01, brown-out reset follows software enable bit 7.
// - other config modes keep bit 7 as plain storage without effect.
// - bit 0 is read-only and shows whether the brown-out circuit is active.
// - bit 7 becomes 1 on power-on and brown-out reset, kept otherwise.
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "borc_cfg.svh"

module borc_brownout_ctrl
    import borc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic undervoltage_reset,
    input wire logic warm_reset,
    input wire logic [1:0] brownout_config_mode,
    input wire logic hw_brownout_enable,
    input wire logic brownout_circuit_active,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`BORC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic brownout_reset_enable
);

    borc_apb_req_t req;
    logic wr_ctrl;
    logic rd_load;
    borc_sel_t rd_sel;

    logic software_brownout_enable_r, software_brownout_enable_nxt;
    logic brownout_circuit_ready_r, brownout_circuit_ready_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic cap_done_r, cap_done_nxt;
    logic enable_r, enable_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [7:0] ctrl_view;
    logic [31:0] stat_view;

    always_comb begin
        req.psel = psel;
        req.penable = penable;
        req.pwrite = pwrite;
        req.paddr = paddr;
        req.pwdata = pwdata;
        req.pstrb = pstrb;
    end

    borc_apb_port u_port (
        .clk(clk),
        .sys_rst(sys_rst),
        .warm_reset(warm_reset),
        .req(req),
        .pready(pready),
        .pslverr(pslverr),
        .wr_ctrl(wr_ctrl),
        .rd_load(rd_load),
        .rd_sel(rd_sel)
    );

    // register view: control has only bits 7 and 0, status only bits 3 to 0
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[`BORC_SWEN_BIT] = software_brownout_enable_r;
        ctrl_view[`BORC_RDY_BIT] = brownout_circuit_ready_r;
        stat_view = 32'h0000_0000;
        stat_view[`BORC_STAT_EN_BIT] = enable_r;
        stat_view[`BORC_STAT_MODE_LSB +: 2] = mode_r;
        stat_view[`BORC_STAT_CAP_BIT] = cap_done_r;
    end

    // strap is caught after reset release, never inside the async reset
    always_comb begin
        mode_nxt = mode_r;
        cap_done_nxt = cap_done_r;
        if (!cap_done_r || undervoltage_reset) begin
            mode_nxt = brownout_config_mode;
            cap_done_nxt = 1'h1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_r <= `BORC_MODE_RST;
            cap_done_r <= 1'h0;
        end else begin
            mode_r <= mode_nxt;
            cap_done_r <= cap_done_nxt;
        end
    end

    // enable bit: brown-out reset forces it set and wins over a write
    always_comb begin
        software_brownout_enable_nxt = software_brownout_enable_r;
        if (undervoltage_reset) begin
            software_brownout_enable_nxt = `BORC_SWEN_RST;
        end else if (wr_ctrl) begin
            software_brownout_enable_nxt = pwdata[`BORC_SWEN_BIT];
        end
        brownout_circuit_ready_nxt = brownout_circuit_active;
    end

    // warm_reset deliberately absent here: bit 7 survives other resets
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            software_brownout_enable_r <= `BORC_SWEN_RST;
            brownout_circuit_ready_r <= 1'h0;
        end else begin
            software_brownout_enable_r <= software_brownout_enable_nxt;
            brownout_circuit_ready_r <= brownout_circuit_ready_nxt;
        end
    end

    // effective enable: software bit only steers in software mode
    always_comb begin
        if (!cap_done_r) begin
            enable_nxt = 1'h1;
        end else if (mode_r == `BORC_MODE_SW) begin
            enable_nxt = software_brownout_enable_r;
        end else begin
            enable_nxt = hw_brownout_enable;
        end
    end

    // read data captured in setup so it is stable for the whole access
    always_comb begin
        prdata_nxt = prdata_r;
        if (warm_reset) begin
            prdata_nxt = 32'h0000_0000;
        end else if (rd_load) begin
            case (rd_sel)
                BORC_SEL_CTRL: prdata_nxt = {24'h00_0000, ctrl_view};
                BORC_SEL_STAT: prdata_nxt = stat_view;
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            enable_r <= 1'h1;
            prdata_r <= 32'h0000_0000;
        end else begin
            enable_r <= enable_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata = prdata_r;
    assign brownout_reset_enable = enable_r;

    property p_sw_mode_follows;
        @(posedge clk) disable iff (sys_rst)
        (cap_done_r && mode_r == `BORC_MODE_SW) |=> (brownout_reset_enable == $past(software_brownout_enable_r));
    endproperty
    a_sw_mode_follows: assert property (p_sw_mode_follows)
        else $error("enable does not follow software bit in software mode");

    property p_hw_mode_ignores;
        @(posedge clk) disable iff (sys_rst)
        (cap_done_r && mode_r != `BORC_MODE_SW) |=> (brownout_reset_enable == $past(hw_brownout_enable));
    endproperty
    a_hw_mode_ignores: assert property (p_hw_mode_ignores)
        else $error("software bit influenced enable outside software mode");

    property p_bit7_stores;
        @(posedge clk) disable iff (sys_rst)
        (psel && penable && pready && pwrite && paddr == `BORC_CTRL_OFFSET && pstrb[0] && !undervoltage_reset)
        |=> (software_brownout_enable_r == $past(pwdata[`BORC_SWEN_BIT]));
    endproperty
    a_bit7_stores: assert property (p_bit7_stores)
        else $error("write to bit 7 not stored");

    property p_ready_read;
        @(posedge clk) disable iff (sys_rst)
        (psel && !penable && !pwrite && paddr == `BORC_CTRL_OFFSET && !warm_reset)
        |=> (prdata[`BORC_RDY_BIT] == $past(brownout_circuit_ready_r))
        ##1 (brownout_circuit_ready_r == $past(brownout_circuit_active));
    endproperty
    a_ready_read: assert property (p_ready_read)
        else $error("ready bit does not reflect circuit state");

    property p_bor_sets;
        @(posedge clk) disable iff (sys_rst)
        undervoltage_reset |=> software_brownout_enable_r;
    endproperty
    a_bor_sets: assert property (p_bor_sets)
        else $error("brown-out reset did not set enable bit");

    property p_warm_keeps;
        @(posedge clk) disable iff (sys_rst)
        (warm_reset && !undervoltage_reset) |=> $stable(software_brownout_enable_r);
    endproperty
    a_warm_keeps: assert property (p_warm_keeps)
        else $error("other reset changed enable bit");

    property p_unused_zero;
        @(posedge clk) disable iff (sys_rst)
        (pready && !pwrite && paddr == `BORC_CTRL_OFFSET)
        |-> (prdata[31:8] == 24'h00_0000 && prdata[6:1] == 6'h00);
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unimplemented bits read nonzero");

    property p_err_unmapped;
        @(posedge clk) disable iff (sys_rst)
        (pready && paddr != `BORC_CTRL_OFFSET && paddr != `BORC_STAT_OFFSET) |-> pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("unmapped access not flagged");

endmodule
`default_nettype wire

// ===== borc_cfg.svh
// offsets, field positions, reset values and timing for the brown-out control block
// assumes inclusion by bare name from the package and the design modules
`ifndef BORC_CFG_SVH
`define BORC_CFG_SVH

`define BORC_ADDR_W 12
`define BORC_CTRL_OFFSET 12'h000
`define BORC_STAT_OFFSET 12'h004
`define BORC_SWEN_BIT 7
`define BORC_RDY_BIT 0
`define BORC_SWEN_RST 1'h1
`define BORC_MODE_SW 2'h1
`define BORC_MODE_RST 2'h0
`define BORC_STAT_EN_BIT 0
`define BORC_STAT_MODE_LSB 1
`define BORC_STAT_CAP_BIT 3
`define BORC_CLK_PERIOD_NS 40

`endif

// ===== borc_pkg.sv
// types shared by the brown-out control block and its bus port
// assumes borc_cfg.svh is on the include path
`include "borc_cfg.svh"

package borc_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`BORC_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } borc_apb_req_t;

    typedef enum logic [2:0] {
        BORC_BUS_IDLE = 3'h1,
        BORC_BUS_SETUP = 3'h2,
        BORC_BUS_ACCESS = 3'h4
    } borc_bus_state_t;

    typedef enum logic [1:0] {
        BORC_SEL_NONE = 2'h0,
        BORC_SEL_CTRL = 2'h1,
        BORC_SEL_STAT = 2'h2
    } borc_sel_t;

endpackage

// ===== borc_apb_port.sv
// APB slave front end: decode in setup, zero-wait answer in access
// assumes an APB master on clk; unmapped addresses answer with pslverr
`timescale 1ns/1ns
`default_nettype none
`include "borc_cfg.svh"

module borc_apb_port
    import borc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic warm_reset,
    input wire borc_apb_req_t req,
    output logic pready,
    output logic pslverr,
    output logic wr_ctrl,
    output logic rd_load,
    output borc_sel_t rd_sel
);

    borc_bus_state_t state_r, state_nxt;
    borc_sel_t sel_r, sel_nxt;
    borc_sel_t dec_sel;

    always_comb begin
        dec_sel = BORC_SEL_NONE;
        if (req.paddr == `BORC_CTRL_OFFSET) begin
            dec_sel = BORC_SEL_CTRL;
        end else if (req.paddr == `BORC_STAT_OFFSET) begin
            dec_sel = BORC_SEL_STAT;
        end
    end

    // setup cycle moves to access, which completes in one cycle; warm_reset during setup returns to idle instead
    always_comb begin
        state_nxt = state_r;
        sel_nxt = sel_r;
        case (state_r)
            BORC_BUS_IDLE, BORC_BUS_ACCESS: begin
                if (req.psel && !req.penable) begin
                    state_nxt = BORC_BUS_SETUP;
                    sel_nxt = dec_sel;
                end else begin
                    state_nxt = BORC_BUS_IDLE;
                end
            end
            BORC_BUS_SETUP: begin
                state_nxt = (req.psel && req.penable) ? BORC_BUS_ACCESS : BORC_BUS_IDLE;
            end
            default: begin
                state_nxt = BORC_BUS_IDLE;
                sel_nxt = BORC_SEL_NONE;
            end
        endcase
        if (warm_reset) begin
            state_nxt = BORC_BUS_IDLE;
            sel_nxt = BORC_SEL_NONE;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= BORC_BUS_IDLE;
            sel_r <= BORC_SEL_NONE;
        end else begin
            state_r <= state_nxt;
            sel_r <= sel_nxt;
        end
    end

    // answer is combinational so the access phase needs no wait state
    always_comb begin
        pready = (state_r == BORC_BUS_SETUP) && req.psel && req.penable;
        pslverr = pready && (sel_r == BORC_SEL_NONE);
        wr_ctrl = pready && req.pwrite && (sel_r == BORC_SEL_CTRL) && req.pstrb[0];
        rd_load = req.psel && !req.penable && !req.pwrite && !warm_reset;
        rd_sel = dec_sel;
    end

endmodule
`default_nettype wire

// ===== borc_brownout_ctrl_test.sv
// self-checking bench for the brown-out control register block
// assumes borc_pkg and borc_cfg.svh are compiled ahead; drives the APB port directly
`timescale 1ns/1ns
`default_nettype none
`include "borc_cfg.svh"

`define CHK_EQ(got, exp) begin total_checks++; if ((got) !== (exp)) begin fails++; \
    $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module borc_brownout_ctrl_test;
    import borc_pkg::*;

    logic clk;
    logic sys_rst;
    logic undervoltage_reset;
    logic warm_reset;
    logic [1:0] brownout_config_mode;
    logic hw_brownout_enable;
    logic brownout_circuit_active;
    logic psel;
    logic penable;
    logic pwrite;
    logic [`BORC_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic brownout_reset_enable;
    logic [31:0] rd;
    logic err;
    int fails;
    int total_checks;

    borc_brownout_ctrl dut_u (
        .clk(clk), .sys_rst(sys_rst), .undervoltage_reset(undervoltage_reset),
        .warm_reset(warm_reset), .brownout_config_mode(brownout_config_mode),
        .hw_brownout_enable(hw_brownout_enable), .brownout_circuit_active(brownout_circuit_active),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .brownout_reset_enable(brownout_reset_enable)
    );

    always #20 clk = ~clk;

    function automatic logic [31:0] ctrl_val(input logic swen, input logic act);
        return {24'h0, swen, 6'h0, act};
    endfunction

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // holds the request until pready is seen high; the wait has no cycle limit of its own
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // no cycle count assumed here: only the watchdog ends a hung wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset(input logic [1:0] mode);
        sys_rst <= 1'b1;
        brownout_config_mode <= mode;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // enable lags the register by a cycle, so let three edges pass first
    task automatic chk_en(input logic exp);
        repeat (3) @(posedge clk);
        `CHK_EQ(brownout_reset_enable, exp)
    endtask

    initial begin
        #(40 * 5000);
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        undervoltage_reset = 1'b0;
        warm_reset = 1'b0;
        brownout_config_mode = `BORC_MODE_SW;
        hw_brownout_enable = 1'b0;
        brownout_circuit_active = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        fails = 0;
        total_checks = 0;
        do_reset(`BORC_MODE_SW);
        apb(1'b0, `BORC_CTRL_OFFSET, 32'h0);
        `CHK_EQ(rd, ctrl_val(1'b1, 1'b1))
        `CHK_EQ(err, 1'b0)
        chk_en(1'b1);
        // reserved bits written high must read back zero
        apb(1'b1, `BORC_CTRL_OFFSET, 32'h0000007E);
        chk_en(1'b0);
        apb(1'b0, `BORC_CTRL_OFFSET, 32'h0);
        `CHK_EQ(rd, ctrl_val(1'b0, 1'b1))
        brownout_circuit_active <= 1'b0;
        apb(1'b1, `BORC_CTRL_OFFSET, 32'h000000FF);
        chk_en(1'b1);
        apb(1'b0, `BORC_CTRL_OFFSET, 32'h0);
        `CHK_EQ(rd, ctrl_val(1'b1, 1'b0))
        apb(1'b0, `BORC_STAT_OFFSET, 32'h0);
        `CHK_EQ(rd, 32'h0000000B)
        // refused accesses: unmapped write and read, and empty byte lane write
        apb(1'b1, 12'h00C, 32'h0);
        `CHK_EQ(err, 1'b1)
        pstrb <= 4'h0;
        apb(1'b1, `BORC_CTRL_OFFSET, 32'h0);
        pstrb <= 4'hF;
        apb(1'b0, 12'h008, 32'h0);
        `CHK_EQ(rd, 32'h0)
        `CHK_EQ(err, 1'b1)
        apb(1'b0, `BORC_CTRL_OFFSET, 32'h0);
        `CHK_EQ(rd, ctrl_val(1'b1, 1'b0))
        brownout_circuit_active <= 1'b1;
        apb(1'b1, `BORC_CTRL_OFFSET, 32'h0);
        warm_reset <= 1'b1;
        @(posedge clk);
        warm_reset <= 1'b0;
        apb(1'b0, `BORC_CTRL_OFFSET, 32'h0);
        `CHK_EQ(rd, ctrl_val(1'b0, 1'b1))
        chk_en(1'b0);
        undervoltage_reset <= 1'b1;
        @(posedge clk);
        undervoltage_reset <= 1'b0;
        apb(1'b0, `BORC_CTRL_OFFSET, 32'h0);
        `CHK_EQ(rd, ctrl_val(1'b1, 1'b1))
        chk_en(1'b1);
        // other strap modes: bit 7 is plain storage, hardware enable rules
        for (int m = 0; m < 4; m++) begin
            if (m != 1) begin
                hw_brownout_enable <= 1'b0;
                do_reset(2'(m));
                chk_en(1'b0);
                hw_brownout_enable <= 1'b1;
                apb(1'b1, `BORC_CTRL_OFFSET, 32'h0);
                chk_en(1'b1);
                apb(1'b0, `BORC_CTRL_OFFSET, 32'h0);
                `CHK_EQ(rd, ctrl_val(1'b0, 1'b1))
                apb(1'b0, `BORC_STAT_OFFSET, 32'h0);
                `CHK_EQ(rd, {28'h0, 1'b1, 2'(m), 1'b1})
            end
        end
        finish_test();
    end
endmodule

`default_nettype wire
